// [design/gph_pkg.sv]
// package: register map, field positions and reset values of the port g/h block
package gph_pkg;
   // ------------------------------------------------------------
   // register byte offsets (aligned words)
   // ------------------------------------------------------------
   localparam logic [5:0] GPH_OFS_G_PIN_VALUE    = 6'h00;
   localparam logic [5:0] GPH_OFS_G_OUTPUT_LATCH = 6'h04;
   localparam logic [5:0] GPH_OFS_G_DIRECTION    = 6'h08;
   localparam logic [5:0] GPH_OFS_H_PIN_VALUE    = 6'h0c;
   localparam logic [5:0] GPH_OFS_H_OUTPUT_LATCH = 6'h10;
   localparam logic [5:0] GPH_OFS_H_DIRECTION    = 6'h14;
   localparam logic [5:0] GPH_OFS_ANALOG_CFG     = 6'h18;
   localparam logic [5:0] GPH_OFS_EXT_BUS_CTRL   = 6'h1c;
   // ------------------------------------------------------------
   // widths and reset values
   // ------------------------------------------------------------
   localparam int         GPH_G_W           = 5;
   localparam int         GPH_H_W           = 8;
   localparam logic [4:0] GPH_G_DIR_RST     = 5'h1f;
   localparam logic [7:0] GPH_H_DIR_RST     = 8'hff;
   localparam logic [7:0] GPH_ANALOG_RST    = 8'h00;
   localparam logic [7:0] GPH_EXT_BUS_RST   = 8'h00;
   localparam logic [4:0] GPH_G_LATCH_RST   = 5'h00;
   localparam logic [7:0] GPH_H_LATCH_RST   = 8'h00;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int         GPH_EXT_BUS_DIS_BIT = 7;     // external_bus_disable
   localparam logic [7:0] GPH_EXT_BUS_MASK    = 8'hb3; // implemented bits
   localparam logic [7:0] GPH_ANALOG_MASK     = 8'h3f; // implemented bits
   localparam logic [3:0] GPH_ANALOG_DIGITAL  = 4'hf;  // pin config code: all digital
   localparam logic [1:0] GPH_RESP_OKAY       = 2'b00;
   localparam logic [1:0] GPH_RESP_SLVERR     = 2'b10;
endpackage

// [design/gph_port.sv]
// port g and port h general-purpose i/o with peripheral pin sharing
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
// Overview of operation
// - direction one tristates, zero drives latch
// - port g has five pins
// - port h has eight pins
// - latch register reads latched value
// - enabled peripheral overrides pin direction
// - override never stored in direction register
// - port g powers up as inputs
// - g bit1/bit2 shared with second serial
// - g bits 0,3,4 shared with capture/compare
// - port g inputs are schmitt buffered
// - h upper nibble shared with analog
// - h lower nibble carries high address
// - h upper defaults analog, reads zero
// - h lower defaults to address bus
module gph_port
   import gph_pkg::*;
(
   // clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   input  wire logic        i_por,
   // axi4-lite write address / data / response
   input  wire logic [5:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   // axi4-lite read address / data
   input  wire logic [5:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   // port g pins
   input  wire logic [4:0]  i_g_pin,
   output logic [4:0]       o_g_pin,
   output logic [4:0]       o_g_pin_oe_n,
   // port h pins
   input  wire logic [7:0]  i_h_pin,
   output logic [7:0]       o_h_pin,
   output logic [7:0]       o_h_pin_oe_n,
   // capture/compare three, four, five on g bits 0,3,4
   input  wire logic [2:0]  i_ccp_enable,
   input  wire logic [2:0]  i_ccp_drive,
   input  wire logic [2:0]  i_ccp_out,
   output logic [2:0]       o_ccp_in,
   // second serial port on g bit1 (transmit/clock) and bit2 (receive/data)
   input  wire logic [1:0]  i_serial_two_enable,
   input  wire logic [1:0]  i_serial_two_drive,
   input  wire logic [1:0]  i_serial_two_out,
   output logic [1:0]       o_serial_two_in,
   // external memory high address bits
   input  wire logic [3:0]  i_high_address_bits,
   // analog configuration seen by the converter
   output logic [7:0]       o_analog_pin_config,
   output logic             o_external_bus_disable
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   // all flops of the block live in one packed struct; the next-state
   // process fills a full copy and the single clocked process stores it
   // (the latch fields are the only ones without an async reset)
   typedef struct packed {
      logic [4:0]  g_latch;     // g output latch
      logic [4:0]  g_dir;       // g direction
      logic [7:0]  h_latch;     // h output latch
      logic [7:0]  h_dir;       // h direction
      logic [7:0]  analog_cfg;  // analog pin configuration
      logic [7:0]  ext_bus;     // external bus control
      logic        aw_full;     // write address held
      logic [5:0]  aw_addr;     // held write address
      logic        w_full;      // write data held
      logic [31:0] w_data;      // held write data
      logic [3:0]  w_strb;      // held strobes
      logic        bvalid;      // write response pending
      logic [1:0]  bresp;       // write response code
      logic        rvalid;      // read data pending
      logic [31:0] rdata;       // read data
      logic [1:0]  rresp;       // read response code
   } gph_state_t;

   gph_state_t state_r;       // registered state
   gph_state_t state_nxt;     // next state
   logic [4:0] g_oe;          // effective g drive
   logic [4:0] g_drv;         // effective g value
   logic [7:0] h_oe;          // effective h drive
   logic [7:0] h_drv;         // effective h value
   logic [4:0] g_pin_read;    // g pin levels
   logic [7:0] h_pin_read;    // h pin levels
   logic       h_upper_dig;   // upper nibble digital
   logic       h_lower_bus;   // lower nibble on address bus
   logic [3:0] h_upper_mask;  // upper read mask
   logic [4:0] g_per_en;      // g peripheral owns direction
   logic [4:0] g_per_drv;     // g peripheral wants output
   logic [4:0] g_per_val;     // g peripheral output value

   // ------------------------------------------------------------
   // pin mux
   // ------------------------------------------------------------
   // peripheral lanes win over the direction bits pin by pin;
   // the stored direction bits are never touched by an override,
   // so software can read-modify-write them while a peripheral runs
   // port h has no peripheral override: its upper nibble follows the
   // analog pin configuration and its lower nibble the external bus
   // enable, both falling back to direction and latch when released
   // map peripheral lanes to g pins: ccp on 0,3,4; serial on 1,2
   always_comb begin
      g_per_en  = {i_ccp_enable[2], i_ccp_enable[1], i_serial_two_enable, i_ccp_enable[0]};
      g_per_drv = {i_ccp_drive[2], i_ccp_drive[1], i_serial_two_drive, i_ccp_drive[0]};
      g_per_val = {i_ccp_out[2], i_ccp_out[1], i_serial_two_out, i_ccp_out[0]};
   end

   // per pin drive selection, one lane per bit
   genvar gi;
   generate
      for (gi = 0; gi < GPH_G_W; gi++) begin : g_lane
         always_comb begin
            if (g_per_en[gi]) begin
               g_oe[gi]  = g_per_drv[gi];
               g_drv[gi] = g_per_val[gi];
            end else begin
               g_oe[gi]  = ~state_r.g_dir[gi];
               g_drv[gi] = state_r.g_latch[gi];
            end
         end
      end
   endgenerate

   // h mux: upper analog vs digital, lower address bus vs io
   always_comb begin
      h_upper_dig  = (state_r.analog_cfg[3:0] == GPH_ANALOG_DIGITAL);
      h_lower_bus  = ~state_r.ext_bus[GPH_EXT_BUS_DIS_BIT];
      h_upper_mask = h_upper_dig ? 4'hf : 4'h0;
      h_oe[7:4]    = ~state_r.h_dir[7:4] & h_upper_mask;
      h_drv[7:4]   = state_r.h_latch[7:4];
      h_oe[3:0]    = h_lower_bus ? 4'hf : ~state_r.h_dir[3:0];
      h_drv[3:0]   = h_lower_bus ? i_high_address_bits : state_r.h_latch[3:0];
      g_pin_read   = i_g_pin;
      h_pin_read   = {i_h_pin[7:4] & h_upper_mask, i_h_pin[3:0]};
   end

   // pin and peripheral outputs
   always_comb begin
      o_g_pin                = g_drv;
      o_g_pin_oe_n           = ~g_oe;
      o_h_pin                = h_drv;
      o_h_pin_oe_n           = ~h_oe;
      o_ccp_in               = {g_pin_read[4], g_pin_read[3], g_pin_read[0]};
      o_serial_two_in        = g_pin_read[2:1];
      o_analog_pin_config    = state_r.analog_cfg;
      o_external_bus_disable = state_r.ext_bus[GPH_EXT_BUS_DIS_BIT];
   end

   // ------------------------------------------------------------
   // bus slave and register file
   // ------------------------------------------------------------
   // bus slave timing, as seen by a master:
   //  - write address and write data are each held in a one-deep slot,
   //    taken at the edge where valid meets ready, in either order
   //  - the register write happens one cycle after both slots are full,
   //    and the response is raised at that same edge
   //  - a pending response blocks the next write until bready is seen
   //  - a read is taken whenever no read data waits, and the data and
   //    response appear at the next edge, held until rready
   //  - unmapped offsets answer with a slave error and change nothing
   //  - only the low byte lane carries register bits
   // byte-lane merge of an 8-bit register
   function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
      merge8 = s[0] ? d[7:0] : old;
   endfunction

   // next state: accept channels, write, answer reads
   always_comb begin
      logic        do_wr;
      logic        do_rd;
      logic [7:0]  wv;
      logic [31:0] rd;
      logic        hit;
      do_wr     = 1'b0;
      do_rd     = 1'b0;
      wv        = 8'h00;
      rd        = 32'h0000_0000;
      hit       = 1'b1;
      state_nxt = state_r;
      // capture address and data in either order
      if (i_awvalid && !state_r.aw_full) begin
         state_nxt.aw_full = 1'b1;
         state_nxt.aw_addr = i_awaddr;
      end
      if (i_wvalid && !state_r.w_full) begin
         state_nxt.w_full = 1'b1;
         state_nxt.w_data = i_wdata;
         state_nxt.w_strb = i_wstrb;
      end
      // perform write when both held and response free
      if (state_r.aw_full && state_r.w_full && !state_r.bvalid) begin
         do_wr             = 1'b1;
         state_nxt.aw_full = 1'b0;
         state_nxt.w_full  = 1'b0;
         state_nxt.bvalid  = 1'b1;
      end
      if (do_wr) begin
         case ({state_r.aw_addr[5:2], 2'b00})
            GPH_OFS_G_PIN_VALUE, GPH_OFS_G_OUTPUT_LATCH: begin
               wv                = merge8({3'b000, state_r.g_latch}, state_r.w_data, state_r.w_strb);
               state_nxt.g_latch = wv[4:0];
            end
            GPH_OFS_G_DIRECTION: begin
               wv              = merge8({3'b000, state_r.g_dir}, state_r.w_data, state_r.w_strb);
               state_nxt.g_dir = wv[4:0];
            end
            GPH_OFS_H_PIN_VALUE, GPH_OFS_H_OUTPUT_LATCH: begin
               state_nxt.h_latch = merge8(state_r.h_latch, state_r.w_data, state_r.w_strb);
            end
            GPH_OFS_H_DIRECTION: begin
               state_nxt.h_dir = merge8(state_r.h_dir, state_r.w_data, state_r.w_strb);
            end
            GPH_OFS_ANALOG_CFG: begin
               state_nxt.analog_cfg = merge8(state_r.analog_cfg, state_r.w_data, state_r.w_strb) & GPH_ANALOG_MASK;
            end
            GPH_OFS_EXT_BUS_CTRL: begin
               state_nxt.ext_bus = merge8(state_r.ext_bus, state_r.w_data, state_r.w_strb) & GPH_EXT_BUS_MASK;
            end
            default: begin
               hit = 1'b0;   // unmapped
            end
         endcase
         state_nxt.bresp = hit ? GPH_RESP_OKAY : GPH_RESP_SLVERR;
      end
      if (state_r.bvalid && i_bready) begin
         state_nxt.bvalid = 1'b0;
      end
      // read: accept when no read data pending
      if (i_arvalid && !state_r.rvalid) begin
         do_rd = 1'b1;
      end
      if (do_rd) begin
         hit = 1'b1;
         case ({i_araddr[5:2], 2'b00})
            GPH_OFS_G_PIN_VALUE:    rd = {27'h0, g_pin_read};
            GPH_OFS_G_OUTPUT_LATCH: rd = {27'h0, state_r.g_latch};
            GPH_OFS_G_DIRECTION:    rd = {27'h0, state_r.g_dir};
            GPH_OFS_H_PIN_VALUE:    rd = {24'h0, h_pin_read};
            GPH_OFS_H_OUTPUT_LATCH: rd = {24'h0, state_r.h_latch};
            GPH_OFS_H_DIRECTION:    rd = {24'h0, state_r.h_dir};
            GPH_OFS_ANALOG_CFG:     rd = {24'h0, state_r.analog_cfg};
            GPH_OFS_EXT_BUS_CTRL:   rd = {24'h0, state_r.ext_bus};
            default: begin
               rd  = 32'h0000_0000;
               hit = 1'b0;
            end
         endcase
         state_nxt.rvalid = 1'b1;
         state_nxt.rdata  = rd;
         state_nxt.rresp  = hit ? GPH_RESP_OKAY : GPH_RESP_SLVERR;
      end else if (state_r.rvalid && i_rready) begin
         state_nxt.rvalid = 1'b0;
      end
      // power-on clears both latches; a register write in the same
      // cycle loses, so the latches leave power-on in a known state
      if (i_por) begin
         state_nxt.g_latch = GPH_G_LATCH_RST;
         state_nxt.h_latch = GPH_H_LATCH_RST;
      end
   end

   // bus outputs
   // ready signals follow the slot state directly, no extra cycle
   always_comb begin
      o_awready = ~state_r.aw_full;
      o_wready  = ~state_r.w_full;
      o_bvalid  = state_r.bvalid;
      o_bresp   = state_r.bresp;
      o_arready = ~state_r.rvalid;
      o_rvalid  = state_r.rvalid;
      o_rdata   = state_r.rdata;
      o_rresp   = state_r.rresp;
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   // reset policy:
   //  - i_rst restores directions, pin configuration and the bus slave
   //  - the output latches keep their contents through i_rst, so a
   //    warm reset does not glitch driven pins to a new level
   //  - i_por clears the latches, but only at an edge where i_rst is
   //    low; release i_rst at least one edge before i_por
   //  - the async reset branch assigns constants only; the latch
   //    fields are simply left out of it
   // i_rst restores control; latches only cleared by power-on
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         // output latches hold through this reset
         state_r.g_dir      <= GPH_G_DIR_RST;
         state_r.h_dir      <= GPH_H_DIR_RST;
         state_r.analog_cfg <= GPH_ANALOG_RST;
         state_r.ext_bus    <= GPH_EXT_BUS_RST;
         state_r.aw_full    <= 1'b0;
         state_r.aw_addr    <= 6'h00;
         state_r.w_full     <= 1'b0;
         state_r.w_data     <= 32'h0000_0000;
         state_r.w_strb     <= 4'h0;
         state_r.bvalid     <= 1'b0;
         state_r.bresp      <= GPH_RESP_OKAY;
         state_r.rvalid     <= 1'b0;
         state_r.rdata      <= 32'h0000_0000;
         state_r.rresp      <= GPH_RESP_OKAY;
      end else begin
         state_r.g_latch    <= state_nxt.g_latch;
         state_r.h_latch    <= state_nxt.h_latch;
         state_r.g_dir      <= state_nxt.g_dir;
         state_r.h_dir      <= state_nxt.h_dir;
         state_r.analog_cfg <= state_nxt.analog_cfg;
         state_r.ext_bus    <= state_nxt.ext_bus;
         state_r.aw_full    <= state_nxt.aw_full;
         state_r.aw_addr    <= state_nxt.aw_addr;
         state_r.w_full     <= state_nxt.w_full;
         state_r.w_data     <= state_nxt.w_data;
         state_r.w_strb     <= state_nxt.w_strb;
         state_r.bvalid     <= state_nxt.bvalid;
         state_r.bresp      <= state_nxt.bresp;
         state_r.rvalid     <= state_nxt.rvalid;
         state_r.rdata      <= state_nxt.rdata;
         state_r.rresp      <= state_nxt.rresp;
      end
   end

endmodule

// [test/gph_pin_model.sv]
// pin-side model: resolves each pad from the device drive and the far-side drive
`timescale 1ns/100ps
module gph_pin_model (
   // device side
   input  wire logic [4:0] i_g_out,
   input  wire logic [4:0] i_g_oe_n,
   input  wire logic [7:0] i_h_out,
   input  wire logic [7:0] i_h_oe_n,
   // far-side drivers, heard only where the device lets go
   input  wire logic [4:0] i_g_ext,
   input  wire logic [7:0] i_h_ext,
   // resolved pad levels
   output logic      [4:0] o_g_lvl,
   output logic      [7:0] o_h_lvl
);
   // -------------------------------------------------
   // pad resolution
   // -------------------------------------------------
   // enable low means the device owns the pad
   assign o_g_lvl = (i_g_oe_n & i_g_ext) | (~i_g_oe_n & i_g_out);
   assign o_h_lvl = (i_h_oe_n & i_h_ext) | (~i_h_oe_n & i_h_out);
endmodule

// [test/gph_port_sva.sv]
// checker: port-level assertions of the port g/h block
`timescale 1ns/100ps
module gph_port_sva
   import gph_pkg::*;
(
   // clock, reset and bus handshakes
   input wire logic        i_core_clk, i_rst,
   input wire logic        i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid,
   input wire logic        i_arvalid, o_arready, o_rvalid, i_rready,
   input wire logic [31:0] o_rdata,
   // pins and peripherals
   input wire logic [4:0]  i_g_pin, o_g_pin_oe_n,
   input wire logic [7:0]  o_h_pin, o_h_pin_oe_n,
   input wire logic [2:0]  i_ccp_enable, i_ccp_drive, i_ccp_out, o_ccp_in,
   input wire logic [1:0]  i_serial_two_enable, i_serial_two_drive, o_serial_two_in,
   input wire logic [4:0]  o_g_pin,
   input wire logic [3:0]  i_high_address_bits,
   input wire logic [7:0]  o_analog_pin_config,
   input wire logic        o_external_bus_disable
);
   // -------------------------------------------------
   // assertions
   // -------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   a_ccp_force_out : assert property (
      i_ccp_enable[0] && i_ccp_drive[0] |-> !o_g_pin_oe_n[0] && o_g_pin[0] == i_ccp_out[0])
      else $error("capture lane zero override not driving");
   a_ser_force_in : assert property (
      i_serial_two_enable[1] && !i_serial_two_drive[1] |-> o_g_pin_oe_n[2]) else $error("receive pin not released");
   a_ccp_pin_in : assert property (
      o_ccp_in == {i_g_pin[4], i_g_pin[3], i_g_pin[0]}) else $error("capture inputs miswired");
   a_ser_pin_in : assert property (
      o_serial_two_in == i_g_pin[2:1]) else $error("serial inputs miswired");
   a_h_upper_analog : assert property (
      o_analog_pin_config[3:0] != 4'hf |-> &o_h_pin_oe_n[7:4]) else $error("analog pin driven");
   a_h_addr_bus : assert property (
      !o_external_bus_disable |-> o_h_pin_oe_n[3:0] == 4'h0 && o_h_pin[3:0] == i_high_address_bits)
      else $error("address bits not on pins");
   a_g_reset_in : assert property (
      $fell(i_rst) && i_ccp_enable == 3'h0 && i_serial_two_enable == 2'h0 |-> &o_g_pin_oe_n)
      else $error("port g not input after reset");
   a_wr_answer : assert property (
      i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid) else $error("write answer late");
   a_rd_answer : assert property (
      i_arvalid && o_arready |=> o_rvalid) else $error("read answer late");
   a_rd_hold : assert property (
      o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)) else $error("read data not held");
   c_write : cover property (i_awvalid && o_awready && i_wvalid && o_wready);
   c_override : cover property (i_ccp_enable[0] && i_ccp_drive[0]);
   c_bus_off : cover property (o_external_bus_disable);
endmodule

bind gph_port gph_port_sva u_sva (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_awvalid(i_awvalid),
   .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid),
   .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready),
   .o_rdata(o_rdata), .i_g_pin(i_g_pin), .o_g_pin_oe_n(o_g_pin_oe_n), .o_h_pin(o_h_pin),
   .o_h_pin_oe_n(o_h_pin_oe_n), .i_ccp_enable(i_ccp_enable), .i_ccp_drive(i_ccp_drive),
   .i_ccp_out(i_ccp_out), .o_ccp_in(o_ccp_in), .i_serial_two_enable(i_serial_two_enable),
   .i_serial_two_drive(i_serial_two_drive), .o_serial_two_in(o_serial_two_in), .o_g_pin(o_g_pin),
   .i_high_address_bits(i_high_address_bits), .o_analog_pin_config(o_analog_pin_config),
   .o_external_bus_disable(o_external_bus_disable));

// [test/gph_port_tb.sv]
// self-checking bench of the port g/h block
`timescale 1ns/100ps
module gph_port_tb;
   import gph_pkg::*;
   // -------------------------------------------------
   // signals
   // -------------------------------------------------
   logic        clk, rst, por;                   // clock, resets
   logic [5:0]  awaddr, araddr;                  // bus addresses
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic [31:0] wdata;                           // write data
   logic [3:0]  wstrb;                           // byte strobes
   logic [2:0]  ccp_en, ccp_drv, ccp_out;        // capture/compare lanes
   logic [1:0]  ser_en, ser_drv, ser_out;        // serial lanes
   logic [3:0]  hab;                             // high address bits
   logic [4:0]  g_ext;                           // far-side drive on g
   logic [7:0]  h_ext;                           // far-side drive on h
   wire  [4:0]  g_lvl, g_o, g_oe_n;
   wire  [7:0]  h_lvl, h_o, h_oe_n, acfg;
   wire  [31:0] rdata;
   wire  [1:0]  bresp, rresp;
   wire         awready, wready, bvalid, arready, rvalid;
   int          mismatches, num_checks, cyc;
   logic [31:0] d, v, w;
   logic [1:0]  r;
   // -------------------------------------------------
   // instances
   // -------------------------------------------------
   gph_port uut (.i_core_clk(clk), .i_rst(rst), .i_por(por), .i_awaddr(awaddr), .i_awvalid(awvalid),
      .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
      .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .i_g_pin(g_lvl), .o_g_pin(g_o), .o_g_pin_oe_n(g_oe_n), .i_h_pin(h_lvl), .o_h_pin(h_o),
      .o_h_pin_oe_n(h_oe_n), .i_ccp_enable(ccp_en), .i_ccp_drive(ccp_drv), .i_ccp_out(ccp_out),
      .o_ccp_in(), .i_serial_two_enable(ser_en), .i_serial_two_drive(ser_drv),
      .i_serial_two_out(ser_out), .o_serial_two_in(), .i_high_address_bits(hab),
      .o_analog_pin_config(acfg), .o_external_bus_disable());
   gph_pin_model u_pins (.i_g_out(g_o), .i_g_oe_n(g_oe_n), .i_h_out(h_o), .i_h_oe_n(h_oe_n),
      .i_g_ext(g_ext), .i_h_ext(h_ext), .o_g_lvl(g_lvl), .o_h_lvl(h_lvl));
   // -------------------------------------------------
   // clock and hang guard
   // -------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         wrap_up();
      end
   end
   // -------------------------------------------------
   // helpers
   // -------------------------------------------------
   // pad level: far side where released, latch where driven
   function automatic logic [7:0] lvl(logic [7:0] dir, logic [7:0] lat, logic [7:0] ext);
      return (dir & ext) | (~dir & lat);
   endfunction
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, g);
         mismatches++;
      end
   endtask
   // bus write: both channels offered together, each released when taken
   task automatic wr(logic [5:0] a, logic [31:0] dat);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge clk);
      awaddr <= a; wdata <= dat; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) begin ad = 1'b1; awvalid <= 1'b0; end
         if (wready) begin wd = 1'b1; wvalid <= 1'b0; end
      end while (!(ad && wd));
      do @(posedge clk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   // bus read: ready raised one cycle late so held data gets looked at
   task automatic rd(logic [5:0] a);
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      @(posedge clk);
      rready <= 1'b1;
      do @(posedge clk); while (!rvalid);
      d = rdata; r = rresp;
      rready <= 1'b0;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // -------------------------------------------------
   // main sequence
   // -------------------------------------------------
   initial begin
      {rst, por} = 2'b11; {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata} = '0;
      {ccp_en, ccp_drv, ccp_out, ser_en, ser_drv, ser_out} = '0; wstrb = 4'hf;
      hab = 4'ha; g_ext = 5'h15; h_ext = 8'hc3; cyc = 0; mismatches = 0; num_checks = 0;
      void'($urandom(69));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      por <= 1'b0;
      rd(GPH_OFS_G_DIRECTION); chk("g_dir", 32'h1f, d);
      rd(GPH_OFS_H_DIRECTION); chk("h_dir", 32'hff, d);
      rd(GPH_OFS_H_PIN_VALUE); chk("h_pin_upper", 32'h0, d & 32'hf0);
      chk("h_low_oe_n", 32'h0, h_oe_n[3:0]);
      rd(6'h20); chk("unmapped_rresp", GPH_RESP_SLVERR, r);
      wr(6'h20, 32'hff); chk("unmapped_bresp", GPH_RESP_SLVERR, r);
      $display("test reset_and_map done");
      for (int i = 0; i < 8; i++) begin
         v = $urandom; w = $urandom; g_ext <= 5'($urandom);
         if (i == 0) w = 32'h0;
         wr(i[0] ? GPH_OFS_G_PIN_VALUE : GPH_OFS_G_OUTPUT_LATCH, v);
         wr(GPH_OFS_G_DIRECTION, w | 32'he0);
         rd(GPH_OFS_G_DIRECTION); chk("g_dir_rb", w & 32'h1f, d);
         rd(GPH_OFS_G_OUTPUT_LATCH); chk("g_latch_rb", v & 32'h1f, d);
         rd(GPH_OFS_G_PIN_VALUE); chk("g_pin_rd", lvl(w[4:0], v[4:0], g_ext), d);
         chk("g_oe_n", w[4:0], g_oe_n);
      end
      $display("test g_direction_latch done");
      wr(GPH_OFS_G_DIRECTION, 32'h1f);
      ccp_en <= 3'h7; ccp_drv <= 3'h5; ccp_out <= 3'($urandom); ser_en <= 2'h3; ser_drv <= 2'h1;
      repeat (2) @(posedge clk);
      chk("g_override_oe_n", {~ccp_drv[2:1], 2'b10, ~ccp_drv[0]}, g_oe_n);
      rd(GPH_OFS_G_DIRECTION); chk("g_dir_kept", 32'h1f, d);
      ccp_en <= 3'h0; ser_en <= 2'h0;
      $display("test override done");
      v = $urandom;
      wr(GPH_OFS_ANALOG_CFG, 32'hff); rd(GPH_OFS_ANALOG_CFG); chk("acfg", GPH_ANALOG_MASK, d);
      chk("acfg_out", GPH_ANALOG_MASK, acfg);
      wr(GPH_OFS_EXT_BUS_CTRL, 32'hff); rd(GPH_OFS_EXT_BUS_CTRL); chk("ebc", GPH_EXT_BUS_MASK, d);
      wr(GPH_OFS_H_OUTPUT_LATCH, v); wr(GPH_OFS_H_DIRECTION, 32'h0);
      chk("h_drive", v[7:0], h_o);
      wr(GPH_OFS_H_DIRECTION, 32'hff); h_ext <= 8'($urandom);
      rd(GPH_OFS_H_PIN_VALUE); chk("h_pin_digital", h_ext, d);
      wr(GPH_OFS_ANALOG_CFG, 32'h0);
      rd(GPH_OFS_H_PIN_VALUE); chk("h_pin_analog", h_ext & 8'h0f, d);
      wr(GPH_OFS_EXT_BUS_CTRL, 32'h0); hab <= 4'($urandom);
      @(posedge clk); chk("h_addr", hab, h_o[3:0]);
      $display("test port_h done");
      wr(GPH_OFS_G_OUTPUT_LATCH, v);
      @(posedge clk); rst <= 1'b1;
      repeat (2) @(posedge clk); rst <= 1'b0;
      rd(GPH_OFS_G_OUTPUT_LATCH); chk("g_latch_kept", v & 32'h1f, d);
      rd(GPH_OFS_H_OUTPUT_LATCH); chk("h_latch_kept", v & 32'hff, d);
      $display("test warm_reset done");
      wrap_up();
   end
endmodule
